// *** mpw_ctrl.sv ***
// Control, status, interrupt and counter readback of a motor PWM unit.
//
// Behaviour
// RQ1: With interval mode set, the period flag is raised only on every Nth period match.
// RQ2: The event-select field picks up events (0), down events in up-down counting (1) or all (2).
// RQ3: The interval target field, 0 to 7, means the first through the eighth period match.
// RQ4: Halt freezes the counter without clearing it and the outputs hold their levels.
// RQ5: The counter advances only while the run enable is set; clearing it stops the PWM.
// RQ6: Every interrupt source is masked by its own enable bit.
// RQ7: Status bit 15 shows the count direction, 1 while counting down.
// RQ8: Status bits 14 to 12 hold the running count of period matches in interval mode.
// RQ9: Status bit 7 is set by a period interrupt event.
// RQ10: Status bit 6 is set by a bottom interrupt event.
// RQ11: Status bits 5 to 0 are set by the six duty compare matches, U high first.
// RQ12: Writing 1 to a flag clears it and writing 0 leaves it alone.
// RQ13: The enable register has one enable per flag in the same bit order.
// RQ14: The counter register reads the live 16-bit count and ignores writes.
// RQ15: The interrupt output is high while any flag is set together with its enable.
// RQ16: Software keeps the period above 0x0010 and every duty compare nonzero.
`timescale 1ns/100ps
module mpw_ctrl
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_up_down_counting,
  input wire logic [mpw_pkg::CNT_W-1:0] i_period,
  input wire logic [5:0] i_duty_match,
  output logic [7:0] o_ctrl_two,
  output logic o_pwm_advance,
  output logic o_irq
);
  import mpw_pkg::*;

  mpw_cnt_if cb();

  // Bus channel state and the captured write beat.
  logic awready_ff;
  logic wready_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Software-visible register contents.
  logic [15:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [7:0] ien_ff;
  logic [7:0] flags_ff;

  // Next-state values of the flag and interval registers, the interval count and the interrupt register.
  logic [7:0] nxt_flags;
  logic [2:0] icnt_ff;
  logic [2:0] nxt_icnt;
  logic irq_ff;

  // Write decode and event selection.
  logic wr_go;
  logic [2:0] wr_idx;
  logic [7:0] clr_bits;
  logic [7:0] set_bits;
  logic [1:0] mode;
  logic allow_up;
  logic allow_dn;
  logic prd_ev;
  logic prd_set;
  logic bot_set;
  logic duty_ok;

  // Maps a byte address to a register index, or none when unmapped.
  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    logic [2:0] idx;
    idx = IDX_NONE;
    // Addresses are compared whole, so a misaligned or foreign address stays unmapped.
    if (addr == ADDR_CTRL1)
      idx = IDX_CTRL1;
    else if (addr == ADDR_CTRL2)
      idx = IDX_CTRL2;
    else if (addr == ADDR_STAT)
      idx = IDX_STAT;
    else if (addr == ADDR_IEN)
      idx = IDX_IEN;
    else if (addr == ADDR_CNT)
      idx = IDX_CNT;
    else if (addr == ADDR_ICLR)
      idx = IDX_ICLR;
    return idx;
  endfunction

  // Merges the two low byte lanes of a write into an old 16-bit value.
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction

  // Control fields handed to the counter.
  assign cb.run = ctrl1_ff[CR1_RUN_BIT];
  assign cb.halt = ctrl1_ff[CR1_HALT_BIT];
  assign cb.up_down = i_up_down_counting;
  assign cb.period = i_period;

  mpw_counter u_cnt
  (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .cb(cb)
  );

  // Bus outputs come straight from their flip-flops.
  assign o_s_axi_awready = awready_ff;
  assign o_s_axi_wready = wready_ff;
  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp = bresp_ff;
  assign o_s_axi_arready = arready_ff;
  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rdata = rdata_ff;
  assign o_s_axi_rresp = rresp_ff;
  assign o_ctrl_two = ctrl2_ff;
  assign o_pwm_advance = cb.advance; // [RQ4]
  assign o_irq = irq_ff;

  // A write is carried out once both address and data are held.
  // Waiting for bvalid to drop keeps a second write behind the pending response.
  assign wr_go = ~awready_ff & ~wready_ff & ~bvalid_ff;
  assign wr_idx = reg_index(awaddr_ff);

  // Write address channel: hold one address until the write is done.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      awready_ff <= 1'b1;
      awaddr_ff <= 32'h00000000;
    end
    else if (awready_ff && i_s_axi_awvalid)
    begin
      awready_ff <= 1'b0;
      awaddr_ff <= i_s_axi_awaddr;
    end
    else if (wr_go)
    begin
      awready_ff <= 1'b1;
    end
  end

  // Write data channel: hold one data beat until the write is done.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wready_ff <= 1'b1;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else if (wready_ff && i_s_axi_wvalid)
    begin
      wready_ff <= 1'b0;
      wdata_ff <= i_s_axi_wdata;
      wstrb_ff <= i_s_axi_wstrb;
    end
    else if (wr_go)
    begin
      wready_ff <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bvalid_ff && i_s_axi_bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // Control register one keeps only its defined bits.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ctrl1_ff <= CR1_RST;
    else if (wr_go && wr_idx == IDX_CTRL1)
      ctrl1_ff <= lane_merge(ctrl1_ff, wdata_ff, wstrb_ff) & CR1_WMASK;
  end

  // Control register two is plain storage for the rest of the unit.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ctrl2_ff <= CR2_RST;
    else if (wr_go && wr_idx == IDX_CTRL2 && wstrb_ff[0])
      ctrl2_ff <= wdata_ff[7:0];
  end

  // Interrupt enables share the flag layout.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ien_ff <= IEN_RST;
    else if (wr_go && wr_idx == IDX_IEN && wstrb_ff[0])
      ien_ff <= wdata_ff[7:0]; // [RQ13]
  end

  // Event selection by mode and count direction.
  assign mode = ctrl1_ff[CR1_MODE_LO +: 2];
  assign allow_up = (mode == MODE_UP) | (mode == MODE_BOTH); // [RQ2]
  assign allow_dn = ((mode == MODE_DOWN) & i_up_down_counting) | (mode == MODE_BOTH); // [RQ2]
  assign prd_ev = cb.top_hit & allow_up;
  assign bot_set = cb.bottom_hit & allow_dn; // [RQ10]
  assign duty_ok = (~cb.down & allow_up) | (cb.down & allow_dn);

  // Interval counting of period matches; target 0..7 is the 1st..8th.
  always_comb
  begin
    nxt_icnt = icnt_ff;
    prd_set = prd_ev; // [RQ9]
    // Outside interval mode every allowed period match sets the flag.
    if (!ctrl1_ff[CR1_INTV_BIT])
    begin
      nxt_icnt = ICNT_RST;
    end
    else if (prd_ev)
    begin
      prd_set = (icnt_ff == ctrl1_ff[CR1_N_LO +: 3]); // [RQ1] [RQ3]
      nxt_icnt = prd_set ? ICNT_RST : icnt_ff + 3'h1; // [RQ8]
    end
  end

  // Interval count register; it rests at zero outside interval mode.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      icnt_ff <= ICNT_RST;
    else
      icnt_ff <= nxt_icnt; // [RQ8]
  end

  // Flag sets and write-one clears; a set in the clear cycle survives.
  assign set_bits = {prd_set, bot_set, i_duty_match & {6{duty_ok}}}; // [RQ11]

  always_comb
  begin
    clr_bits = 8'h00;
    if (wr_go && wstrb_ff[0] && (wr_idx == IDX_STAT || wr_idx == IDX_ICLR))
      clr_bits = wdata_ff[7:0]; // [RQ12]
    nxt_flags = (flags_ff & ~clr_bits) | set_bits; // [RQ12]
  end

  // Flag register, cleared only by reset or by a write of ones.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      flags_ff <= FLAG_RST;
    else
      flags_ff <= nxt_flags;
  end

  // Level interrupt while an enabled flag is set.
  // The output lags the flags by one cycle so that it comes from a flip-flop.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(flags_ff & ien_ff); // [RQ6] [RQ15]
  end

  // Read channel: one read at a time, data registered one cycle later.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end
    else if (arready_ff && i_s_axi_arvalid)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h00000000;
      // Bits outside a register's width read as zero.
      case (reg_index(i_s_axi_araddr))
        IDX_CTRL1: rdata_ff[15:0] <= ctrl1_ff;
        IDX_CTRL2: rdata_ff[7:0] <= ctrl2_ff;
        IDX_STAT:
        begin
          rdata_ff[SR_DOWN_BIT] <= cb.down; // [RQ7]
          rdata_ff[SR_ICNT_LO +: 3] <= icnt_ff; // [RQ8]
          rdata_ff[7:0] <= flags_ff;
        end
        IDX_IEN: rdata_ff[7:0] <= ien_ff;
        IDX_CNT: rdata_ff[15:0] <= cb.count; // [RQ14]
        IDX_ICLR: rdata_ff <= 32'h00000000;
        default: rresp_ff <= RESP_SLVERR;
      endcase
    end
    else if (rvalid_ff && i_s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end
endmodule

// *** mpw_pkg.sv ***
// Shared constants for the motor PWM control and interrupt block.
package mpw_pkg;
  localparam int CNT_W = 16;
  localparam logic [31:0] ADDR_CTRL1 = 32'h40004028;
  localparam logic [31:0] ADDR_CTRL2 = 32'h4000402C;
  localparam logic [31:0] ADDR_STAT = 32'h40004030;
  localparam logic [31:0] ADDR_IEN = 32'h40004034;
  localparam logic [31:0] ADDR_CNT = 32'h40004038;
  localparam logic [31:0] ADDR_ICLR = 32'h40004050;
  localparam logic [2:0] IDX_CTRL1 = 3'h0;
  localparam logic [2:0] IDX_CTRL2 = 3'h1;
  localparam logic [2:0] IDX_STAT = 3'h2;
  localparam logic [2:0] IDX_IEN = 3'h3;
  localparam logic [2:0] IDX_CNT = 3'h4;
  localparam logic [2:0] IDX_ICLR = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam int CR1_INTV_BIT = 15;
  localparam int CR1_MODE_LO = 12;
  localparam int CR1_N_LO = 8;
  localparam int CR1_RUN_BIT = 7;
  localparam int CR1_HALT_BIT = 0;
  localparam logic [15:0] CR1_WMASK = 16'hB781;
  localparam logic [15:0] CR1_RST = 16'h0000;
  localparam logic [7:0] CR2_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [2:0] ICNT_RST = 3'h0;
  localparam int SR_DOWN_BIT = 15;
  localparam int SR_ICNT_LO = 12;
  localparam int FLAG_PRD = 7;
  localparam int FLAG_BOT = 6;
  localparam logic [1:0] MODE_UP = 2'h0;
  localparam logic [1:0] MODE_DOWN = 2'h1;
  localparam logic [1:0] MODE_BOTH = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** mpw_cnt_if.sv ***
// Signals between the register block and the PWM counter.
`timescale 1ns/100ps
interface mpw_cnt_if;
  logic run;
  logic halt;
  logic up_down;
  logic [15:0] period;
  logic [15:0] count;
  logic down;
  logic top_hit;
  logic bottom_hit;
  logic advance;
  modport ctl(output run, halt, up_down, period,
              input count, down, top_hit, bottom_hit, advance);
  modport cnt(input run, halt, up_down, period,
              output count, down, top_hit, bottom_hit, advance);
endinterface

// *** mpw_counter.sv ***
// PWM counter with halt, enable, up and up-down counting.
`timescale 1ns/100ps
module mpw_counter
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  mpw_cnt_if.cnt cb
);
  import mpw_pkg::*;
  logic [CNT_W-1:0] count_ff;
  logic down_ff;
  logic top_ff;
  logic bot_ff;
  logic adv_ff;
  logic step;
  logic at_top;

  // The counter moves only when enabled and not halted.
  assign step = cb.run & ~cb.halt;
  assign at_top = (count_ff >= cb.period);
  assign cb.count = count_ff;
  assign cb.down = down_ff;
  assign cb.top_hit = top_ff;
  assign cb.bottom_hit = bot_ff;
  assign cb.advance = adv_ff;

  // Count and direction; disable clears, halt freezes in place.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      count_ff <= '0;
      down_ff <= 1'b0;
    end
    else if (!cb.run)
    begin
      count_ff <= '0; // [RQ5]
      down_ff <= 1'b0;
    end
    else if (step) // [RQ4]
    begin
      if (!cb.up_down || !down_ff)
      begin
        if (at_top)
        begin
          count_ff <= cb.up_down ? count_ff - 16'h0001 : '0;
          down_ff <= cb.up_down;
        end
        else
        begin
          count_ff <= count_ff + 16'h0001;
          down_ff <= 1'b0;
        end
      end
      else if (count_ff == '0)
      begin
        count_ff <= count_ff + 16'h0001;
        down_ff <= 1'b0;
      end
      else
      begin
        count_ff <= count_ff - 16'h0001;
      end
    end
  end

  // One-cycle strobes at the period match and at the bottom.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      top_ff <= 1'b0;
      bot_ff <= 1'b0;
      adv_ff <= 1'b0;
    end
    else
    begin
      top_ff <= step & at_top & (~cb.up_down | ~down_ff);
      bot_ff <= step & (count_ff == '0) & (~cb.up_down | down_ff);
      adv_ff <= step; // [RQ5]
    end
  end
endmodule

// *** mpw_ctrl_sva.sv ***
// Port checks for the motor PWM control and interrupt block.
`timescale 1ns/100ps
module mpw_ctrl_sva
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic o_pwm_advance,
  input wire logic o_irq
);
  import mpw_pkg::*;
  logic take;
  logic to_cr1;
  // Address and data of one write taken at the same edge.
  assign take = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  assign to_cr1 = take && i_s_axi_awaddr == ADDR_CTRL1;
  default clocking dcb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  AST_B_HOLD:
    assert property (o_s_axi_bvalid && !i_s_axi_bready
      |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("response not held");
  AST_R_LAT:
    assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
      else $error("read answer late");
  AST_W_ORDER:
    assert property (take |=> !o_s_axi_awready && !o_s_axi_wready ##1 o_s_axi_bvalid)
      else $error("write answer late");
  AST_CNT_WR:
    assert property (take && i_s_axi_awaddr == ADDR_CNT
      |-> ##2 o_s_axi_bvalid && o_s_axi_bresp == RESP_OKAY) else $error("count write refused");
  AST_STOP:
    assert property (to_cr1 && (!i_s_axi_wdata[7] || i_s_axi_wdata[0]) |-> ##3 !o_pwm_advance)
      else $error("counter still advancing");
  AST_RUN:
    assert property (to_cr1 && i_s_axi_wdata[7] && !i_s_axi_wdata[0] |-> ##3 o_pwm_advance)
      else $error("counter not advancing");
  AST_MASK:
    assert property (take && i_s_axi_awaddr == ADDR_IEN && i_s_axi_wdata[7:0] == 8'h00
      |-> ##3 !o_irq) else $error("masked request still high");
  AST_IRQ_FALL:
    assert property ($fell(o_irq) |-> $past(o_s_axi_bvalid) || $past(o_s_axi_bvalid, 2))
      else $error("request dropped without a write");
endmodule

// *** tb_top.sv ***
// Self-checking bench for the motor PWM control and interrupt block.
`timescale 1ns/100ps
module tb_top;
  import mpw_pkg::*;
  localparam logic [15:0] PER = 16'h0020;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  logic arv = 1'b0, rrdy = 1'b0, updn = 1'b0;
  logic [31:0] awa = '0, wd = '0, ara = '0;
  logic [5:0] duty = 6'h00;
  logic awr, wrdy, bv, arr, rvld, irq, adv;
  logic [1:0] bresp, rresp;
  logic [7:0] ctl2;
  logic [31:0] rdata, rv, v1;
  int n_errors = 0;
  int n_compared = 0;
  // Block under test; the period stays at a legal value above 0x0010.
  mpw_ctrl dut_u (
    .i_sys_clk(clk), .i_resetn(rst_n), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(brdy),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvld), .i_s_axi_rready(rrdy),
    .i_up_down_counting(updn), .i_period(PER), .i_duty_match(duty), .o_ctrl_two(ctl2),
    .o_pwm_advance(adv), .o_irq(irq));
  // The clock toggles every 2 ns.
  always #2 clk = ~clk;
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Offers address and data together; the response is taken two cycles late.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clk);
      awv <= awv && !awr;
      wv <= wv && !wrdy;
    end while ((awv && !awr) || (wv && !wrdy));
    repeat (2) @(posedge clk);
    brdy <= 1'b1;
    do @(posedge clk); while (!bv);
    brdy <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk);
  endtask
  // Reads one register and compares the masked value.
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    @(posedge clk);
    rrdy <= 1'b1;
    do @(posedge clk); while (!rvld);
    rrdy <= 1'b0;
    rv = rdata;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    chk("rdata", rv & m, e);
    @(posedge clk);
  endtask
  // Gives the comparators a one-cycle strobe, then lets the flag settle.
  task automatic pulse(input logic [5:0] b);
    duty <= b;
    @(posedge clk);
    duty <= 6'h00;
    repeat (3) @(posedge clk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main test sequence.
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_STAT, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd(ADDR_CNT, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    wr(ADDR_IEN, 32'hA5, RESP_OKAY);
    rd(ADDR_IEN, 32'hFFFFFFFF, 32'hA5, RESP_OKAY);
    wr(ADDR_IEN, 32'h0, RESP_OKAY);
    wr(32'h40004100, 32'h1, RESP_SLVERR);
    rd(32'h40004100, 32'h0, 32'h0, RESP_SLVERR);
    // Control register two is plain storage shown on its own output.
    wr(ADDR_CTRL2, 32'h5A, RESP_OKAY);
    rd(ADDR_CTRL2, 32'hFFFFFFFF, 32'h5A, RESP_OKAY);
    chk("ctrl two", {24'h0, ctl2}, 32'h5A);
    // Each duty strobe sets only its own flag; masked sources stay quiet.
    wr(ADDR_CTRL1, 32'h0080, RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_STAT, 32'hFF, RESP_OKAY);
      pulse(6'h01 << i);
      rd(ADDR_STAT, 32'h3F, 32'h1 << i, RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    // Writing zero keeps a flag, writing one clears it; the enable gates it.
    wr(ADDR_STAT, 32'h0, RESP_OKAY);
    rd(ADDR_STAT, 32'h3F, 32'h20, RESP_OKAY);
    wr(ADDR_IEN, 32'h10, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(ADDR_IEN, 32'h20, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(ADDR_STAT, 32'h20, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h0);
    // The flag-clear alias clears by writing ones and always reads zero.
    pulse(6'h04);
    wr(ADDR_ICLR, 32'h04, RESP_OKAY);
    rd(ADDR_STAT, 32'h3F, 32'h0, RESP_OKAY);
    rd(ADDR_ICLR, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    // Period and bottom events with all events selected.
    wr(ADDR_CTRL1, 32'h2080, RESP_OKAY);
    wr(ADDR_STAT, 32'hFF, RESP_OKAY);
    wr(ADDR_IEN, 32'h80, RESP_OKAY);
    repeat (PER + 8) @(posedge clk);
    rd(ADDR_STAT, 32'hC0, 32'hC0, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(ADDR_IEN, 32'h0, RESP_OKAY);
    // Up-counting duty matches count in event selects 0 and 2 only.
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_CTRL1, 32'h0080 | (m << 12), RESP_OKAY);
      wr(ADDR_STAT, 32'hFF, RESP_OKAY);
      pulse(6'h20);
      rd(ADDR_STAT, 32'h20, (m == 0 || m == 2) ? 32'h20 : 32'h0, RESP_OKAY);
    end
    // Interval target 2 raises the period flag on the third match only.
    wr(ADDR_CTRL1, 32'h0, RESP_OKAY);
    wr(ADDR_STAT, 32'hFF, RESP_OKAY);
    wr(ADDR_CTRL1, 32'h8280, RESP_OKAY);
    repeat (2 * PER + 16) @(posedge clk);
    rd(ADDR_STAT, 32'hF080, 32'h2000, RESP_OKAY);
    repeat (PER - 2) @(posedge clk);
    rd(ADDR_STAT, 32'hF080, 32'h0080, RESP_OKAY);
    // The count moves while running, freezes under halt and ignores writes.
    rd(ADDR_CNT, 32'h0, 32'h0, RESP_OKAY);
    v1 = rv;
    rd(ADDR_CNT, 32'h0, 32'h0, RESP_OKAY);
    chk("count moves", {31'h0, v1 !== rv}, 32'h1);
    wr(ADDR_CTRL1, 32'h0081, RESP_OKAY);
    chk("advance", {31'h0, adv}, 32'h0);
    rd(ADDR_CNT, 32'h0, 32'h0, RESP_OKAY);
    v1 = rv;
    wr(ADDR_CNT, 32'h1234, RESP_OKAY);
    rd(ADDR_CNT, 32'hFFFF, v1, RESP_OKAY);
    wr(ADDR_CTRL1, 32'h0, RESP_OKAY);
    rd(ADDR_CNT, 32'hFFFF, 32'h0, RESP_OKAY);
    // Up-down counting shows the downward half in the status word.
    updn <= 1'b1;
    wr(ADDR_CTRL1, 32'h0080, RESP_OKAY);
    repeat (PER + 4) @(posedge clk);
    rd(ADDR_STAT, 32'h8000, 32'h8000, RESP_OKAY);
    // Control register one keeps only its defined fields.
    wr(ADDR_CTRL1, 32'hFFFF, RESP_OKAY);
    rd(ADDR_CTRL1, 32'hFFFFFFFF, 32'hB781, RESP_OKAY);
    summarize();
  end
  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
// Attaches the port checks to the block.
bind mpw_ctrl mpw_ctrl_sva chk_u (.i_sys_clk, .i_resetn, .i_s_axi_awaddr, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
  .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid,
  .o_pwm_advance, .o_irq);
